// ===== inc/pmic_flags_pkg.sv
// Shared constants and carriers for the fault and event flag block.
// Assumes one 25 MHz clock and a synchronous active-high reset.
`default_nettype none

package pmic_flags_pkg;

    // ==========================================================
    // Register map
    localparam logic [7:0] REG_FLAGS = 8'h02;
    localparam logic [7:0] REG_MASKS = 8'h03;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_CAUSE = 8'h05;

    // ==========================================================
    // Field positions
    localparam int FLAG_VENDOR_BIT = 7;
    localparam int FLAG_SHUTDOWN_BIT = 3;
    localparam int FLAG_DIE_HOT_BIT = 0;
    localparam int LIVE_HOT_BIT = 0;
    localparam int CAUSE_PIN_BIT = 3;
    localparam int CAUSE_UV_BIT = 2;
    localparam int CAUSE_FAULT_BIT = 1;
    localparam int CAUSE_CRIT_BIT = 0;

    // ==========================================================
    // Reset values and writable bit sets
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] MASKS_RESET = 8'hFF;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] CAUSE_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_DATA = 8'h00;
    localparam logic [7:0] FLAGS_WRITABLE = 8'h89;
    localparam logic [7:0] MASKS_WRITABLE = 8'h89;
    localparam logic [7:0] CAUSE_WRITABLE = 8'h0F;

    // ==========================================================
    // Serial target port
    localparam logic [6:0] TARGET_ADDR_DEFAULT = 7'h5E;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // ==========================================================
    // Carriers
    localparam int RAIL_COUNT = 8;
    localparam int OC_COUNT = 4;

    typedef struct packed {
        logic [RAIL_COUNT-1:0] rail_good;
        logic [OC_COUNT-1:0] overcurrent;
        logic die_hot;
        logic die_critical;
        logic undervoltage;
        logic power_fault_off;
        logic external_enable_pin;
    } analog_type;

    typedef struct packed {
        logic write;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_access_type;

endpackage

`default_nettype wire

// ===== verilog/i2c_reg_target.sv
// Byte-wide register access over a 7-bit addressed serial target port.
// Assumes the clock oversamples the serial clock at least eight times.
`default_nettype none

module i2c_reg_target
    import pmic_flags_pkg::*;
#(
    parameter logic [6:0] TARGET_ADDR = TARGET_ADDR_DEFAULT
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Serial pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_oe_n_o,
    // Register side
    output reg_access_type access_o,
    output logic [7:0] read_addr_o,
    input wire logic [7:0] rdata_i
);

    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WRITE, ST_WRITE_ACK, ST_READ, ST_READ_ACK
    } target_state_type;

    // ==========================================================
    // Pin synchronisers
    logic scl_meta_q, scl_q, scl_prev_q;
    logic sda_meta_q, sda_q, sda_prev_q;
    logic scl_rise, scl_fall, start_seen, stop_seen;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scl_meta_q <= 1'h1;
            scl_q <= 1'h1;
            scl_prev_q <= 1'h1;
            sda_meta_q <= 1'h1;
            sda_q <= 1'h1;
            sda_prev_q <= 1'h1;
        end else begin
            scl_meta_q <= scl_i;
            scl_q <= scl_meta_q;
            scl_prev_q <= scl_q;
            sda_meta_q <= sda_i;
            sda_q <= sda_meta_q;
            sda_prev_q <= sda_q;
        end
    end

    assign scl_rise = scl_q & ~scl_prev_q;
    assign scl_fall = ~scl_q & scl_prev_q;
    assign start_seen = scl_q & scl_prev_q & sda_prev_q & ~sda_q;
    assign stop_seen = scl_q & scl_prev_q & ~sda_prev_q & sda_q;

    // ==========================================================
    // Byte engine
    target_state_type state_q, state_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] shift_q, shift_d, ptr_q, ptr_d;
    logic read_q, read_d, first_q, first_d, oe_n_q, oe_n_d;
    reg_access_type acc_q, acc_d;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        shift_d = shift_q;
        ptr_d = ptr_q;
        read_d = read_q;
        first_d = first_q;
        oe_n_d = oe_n_q;
        acc_d = acc_q;
        acc_d.write = 1'h0;
        if (stop_seen) begin
            state_d = ST_IDLE;
            oe_n_d = 1'h1;
        end else if (start_seen) begin
            // Repeated start keeps the pointer for a following read
            state_d = ST_ADDR;
            cnt_d = 4'h0;
            oe_n_d = 1'h1;
        end else begin
            case (state_q)
                ST_ADDR, ST_WRITE: begin
                    if (scl_rise) begin
                        shift_d = {shift_q[6:0], sda_q};
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == BITS_PER_BYTE) begin
                        if (state_q == ST_ADDR) begin
                            if (shift_q[7:1] == TARGET_ADDR) begin
                                state_d = ST_ADDR_ACK;
                                read_d = shift_q[0];
                                oe_n_d = 1'h0;
                            end else begin
                                state_d = ST_IDLE;
                            end
                        end else begin
                            state_d = ST_WRITE_ACK;
                            oe_n_d = 1'h0;
                            if (first_q) begin
                                ptr_d = shift_q;
                                first_d = 1'h0;
                            end else begin
                                acc_d.write = 1'h1;
                                acc_d.addr = ptr_q;
                                acc_d.wdata = shift_q;
                                ptr_d = ptr_q + 8'h01;
                            end
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        cnt_d = 4'h0;
                        first_d = 1'h1;
                        if (read_q) begin
                            state_d = ST_READ;
                            shift_d = rdata_i;
                            oe_n_d = rdata_i[7];
                        end else begin
                            state_d = ST_WRITE;
                            oe_n_d = 1'h1;
                        end
                    end
                end
                ST_WRITE_ACK: begin
                    if (scl_fall) begin
                        state_d = ST_WRITE;
                        cnt_d = 4'h0;
                        oe_n_d = 1'h1;
                    end
                end
                ST_READ: begin
                    if (scl_rise) begin
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt_q == BITS_PER_BYTE) begin
                            state_d = ST_READ_ACK;
                            oe_n_d = 1'h1;
                            ptr_d = ptr_q + 8'h01;
                        end else begin
                            shift_d = {shift_q[6:0], 1'h0};
                            oe_n_d = shift_q[6];
                        end
                    end
                end
                ST_READ_ACK: begin
                    if (scl_rise) begin
                        cnt_d = 4'h0;
                        if (sda_q) begin
                            state_d = ST_IDLE;
                        end
                    end else if (scl_fall) begin
                        state_d = ST_READ;
                        shift_d = rdata_i;
                        oe_n_d = rdata_i[7];
                    end
                end
                default: begin
                    state_d = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
            cnt_q <= 4'h0;
            shift_q <= 8'h00;
            ptr_q <= 8'h00;
            read_q <= 1'h0;
            first_q <= 1'h0;
            oe_n_q <= 1'h1;
            acc_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            shift_q <= shift_d;
            ptr_q <= ptr_d;
            read_q <= read_d;
            first_q <= first_d;
            oe_n_q <= oe_n_d;
            acc_q <= acc_d;
        end
    end

    assign sda_oe_n_o = oe_n_q;
    assign access_o = acc_q;
    assign read_addr_o = ptr_q;

endmodule

`default_nettype wire

// ===== verilog/pmic_fault_event_flags.sv
// Sticky fault and shutdown flags, masks and live thermal status.
// Assumes analog inputs are asynchronous levels and the host uses the serial port.
`default_nettype none

module pmic_fault_event_flags
    import pmic_flags_pkg::*;
#(
    parameter logic [6:0] TARGET_ADDR = TARGET_ADDR_DEFAULT
) (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RST_I,
    // Serial target pins
    input wire logic SCL_I,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE_N_O,
    // Analog detector levels
    input wire analog_type ANALOG_I,
    // Host interrupt request
    output logic INT_REQ_O
);

    // ==========================================================
    // Serial access
    reg_access_type access;
    logic [7:0] read_addr;
    logic [7:0] rdata;

    i2c_reg_target #(
        .TARGET_ADDR(TARGET_ADDR)
    ) u_target (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .scl_i(SCL_I),
        .sda_i(SDA_I),
        .sda_oe_n_o(SDA_OE_N_O),
        .access_o(access),
        .read_addr_o(read_addr),
        .rdata_i(rdata)
    );

    // Open drain: only ever pulls low
    assign SDA_O = 1'h0;

    // ==========================================================
    // Detector synchronisers and edges
    analog_type meta_q, cur_q, prev_q;

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            meta_q <= '0;
            cur_q <= '0;
            prev_q <= '0;
        end else begin
            meta_q <= ANALOG_I;
            cur_q <= meta_q;
            prev_q <= cur_q;
        end
    end

    logic rail_drop, oc_rise, hot_rise, crit_rise, uv_rise, fault_rise, pin_fall;

    // Rails start low out of reset, so only a seen-high rail can drop
    assign rail_drop = |(prev_q.rail_good & ~cur_q.rail_good);
    assign oc_rise = |(cur_q.overcurrent & ~prev_q.overcurrent);
    assign hot_rise = cur_q.die_hot & ~prev_q.die_hot;
    assign crit_rise = cur_q.die_critical & ~prev_q.die_critical;
    assign uv_rise = cur_q.undervoltage & ~prev_q.undervoltage;
    assign fault_rise = cur_q.power_fault_off & ~prev_q.power_fault_off;
    assign pin_fall = prev_q.external_enable_pin & ~cur_q.external_enable_pin;

    // ==========================================================
    // Register file
    function automatic logic [7:0] sticky_next(
        input logic [7:0] cur,
        input logic [7:0] set,
        input logic [7:0] clr,
        input logic [7:0] writable
    );
        // Set after clear so a coincident event is kept
        return (cur & ~(clr & writable)) | set;
    endfunction

    logic [7:0] flags_q, flags_d, masks_q, masks_d, cause_q, cause_d;
    logic live_q, live_d, irq_q, irq_d;
    logic [7:0] flag_set, cause_set, flag_clr, cause_clr;

    always_comb begin
        cause_set = CAUSE_RESET;
        cause_set[CAUSE_PIN_BIT] = pin_fall;
        cause_set[CAUSE_UV_BIT] = uv_rise;
        cause_set[CAUSE_FAULT_BIT] = fault_rise;
        cause_set[CAUSE_CRIT_BIT] = crit_rise;
        flag_set = FLAGS_RESET;
        flag_set[FLAG_VENDOR_BIT] = rail_drop | oc_rise | hot_rise | crit_rise;
        flag_set[FLAG_SHUTDOWN_BIT] = |cause_set;
        flag_set[FLAG_DIE_HOT_BIT] = hot_rise;
        flag_clr = 8'h00;
        cause_clr = 8'h00;
        masks_d = masks_q;
        if (access.write) begin
            if (access.addr == REG_FLAGS) begin
                flag_clr = access.wdata;
            end else if (access.addr == REG_MASKS) begin
                masks_d = (masks_q & ~MASKS_WRITABLE) | (access.wdata & MASKS_WRITABLE);
            end else if (access.addr == REG_CAUSE) begin
                cause_clr = access.wdata;
            end
        end
        flags_d = sticky_next(flags_q, flag_set, flag_clr, FLAGS_WRITABLE);
        cause_d = sticky_next(cause_q, cause_set, cause_clr, CAUSE_WRITABLE);
        live_d = cur_q.die_hot;
        irq_d = |(flags_d & ~masks_d);
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            flags_q <= FLAGS_RESET;
            masks_q <= MASKS_RESET;
            cause_q <= CAUSE_RESET;
            live_q <= 1'h0;
            irq_q <= 1'h0;
        end else begin
            flags_q <= flags_d;
            masks_q <= masks_d;
            cause_q <= cause_d;
            live_q <= live_d;
            irq_q <= irq_d;
        end
    end

    // ==========================================================
    // Read path, reserved bits read as stored constants
    always_comb begin
        if (read_addr == REG_FLAGS) begin
            rdata = flags_q;
        end else if (read_addr == REG_MASKS) begin
            rdata = masks_q;
        end else if (read_addr == REG_STATUS) begin
            rdata = STATUS_RESET;
            rdata[LIVE_HOT_BIT] = live_q;
        end else if (read_addr == REG_CAUSE) begin
            rdata = cause_q;
        end else begin
            rdata = UNMAPPED_DATA;
        end
    end

    assign INT_REQ_O = irq_q;

    // ==========================================================
    // Checks
    a_vendor_on_rail:
    assert property (@(posedge CLK_I) disable iff (RST_I)
        $fell(cur_q.rail_good[0]) |=> flags_q[FLAG_VENDOR_BIT])
    else $error("rail loss did not set vendor flag");

    a_hot_flags:
    assert property (@(posedge CLK_I) disable iff (RST_I)
        hot_rise |=> flags_q[FLAG_DIE_HOT_BIT] && flags_q[FLAG_VENDOR_BIT] && live_q)
    else $error("hot crossing not recorded");

    a_uv_cause:
    assert property (@(posedge CLK_I) disable iff (RST_I)
        $rose(cur_q.undervoltage) |=> cause_q[CAUSE_UV_BIT] && flags_q[FLAG_SHUTDOWN_BIT])
    else $error("undervoltage cause or event flag missing");

    a_crit_cause:
    assert property (@(posedge CLK_I) disable iff (RST_I)
        crit_rise |=> cause_q[CAUSE_CRIT_BIT] && flags_q[FLAG_SHUTDOWN_BIT])
    else $error("critical cause or event flag missing");

    a_pin_cause:
    assert property (@(posedge CLK_I) disable iff (RST_I)
        $fell(cur_q.external_enable_pin) |=> cause_q[CAUSE_PIN_BIT])
    else $error("pin shutdown cause missing");

    a_fault_cause:
    assert property (@(posedge CLK_I) disable iff (RST_I)
        fault_rise |=> cause_q[CAUSE_FAULT_BIT] && flags_q[FLAG_SHUTDOWN_BIT])
    else $error("power fault cause missing");

    a_flag_sticky:
    assert property (@(posedge CLK_I) disable iff (RST_I)
        flags_q[FLAG_DIE_HOT_BIT] && !(access.write && access.addr == REG_FLAGS)
        |=> flags_q[FLAG_DIE_HOT_BIT])
    else $error("die hot flag dropped without a clear");

    a_set_beats_clear:
    assert property (@(posedge CLK_I) disable iff (RST_I)
        access.write && access.addr == REG_CAUSE && access.wdata[CAUSE_UV_BIT] && uv_rise
        |=> cause_q[CAUSE_UV_BIT])
    else $error("coincident clear lost an event");

    a_clear_works:
    assert property (@(posedge CLK_I) disable iff (RST_I)
        access.write && access.addr == REG_CAUSE && access.wdata[CAUSE_FAULT_BIT]
        && !fault_rise |=> !cause_q[CAUSE_FAULT_BIT])
    else $error("cause bit not cleared by one");

    a_irq_gate:
    assert property (@(posedge CLK_I) disable iff (RST_I)
        ##1 (INT_REQ_O == |(flags_q & ~masks_q)))
    else $error("interrupt request disagrees with flags and masks");

    a_reset_values:
    assert property (@(posedge CLK_I)
        $past(RST_I) && !RST_I |-> flags_q == FLAGS_RESET && cause_q == CAUSE_RESET
        && masks_q == MASKS_RESET && !INT_REQ_O)
    else $error("wrong value after reset");

endmodule

`default_nettype wire

// ===== tb/i2c_host_model.sv
// Host side of the serial register port: drives the clock and data pins.
// Assumes a pulled-up data wire resolved by the bench and fed back on sda_i.
`default_nettype none

module i2c_host_model
    import pmic_flags_pkg::*;
#(
    parameter logic [6:0] TARGET_ADDR = TARGET_ADDR_DEFAULT
) (
    // Clock
    input wire logic clk_i,
    // Serial pins
    output logic scl_o,
    output logic sda_o,
    input wire logic sda_i
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    // ==========================================================
    // Pin timing
    // Phases of 10 clocks keep clear of the 8-clock minimum.
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic start();
        sda_o = 1'b1;
        tick(5);
        scl_o = 1'b1;
        tick(10);
        sda_o = 1'b0;
        tick(10);
        scl_o = 1'b0;
    endtask

    task automatic stop();
        sda_o = 1'b0;
        tick(10);
        scl_o = 1'b1;
        tick(10);
        sda_o = 1'b1;
        tick(10);
    endtask

    // Sampled late in the high phase, long after the target settles
    task automatic one_bit(input logic b, output logic r);
        sda_o = b;
        tick(10);
        scl_o = 1'b1;
        tick(10);
        r = sda_i;
        scl_o = 1'b0;
    endtask

    // ==========================================================
    // Byte level
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            one_bit(d[i], r);
        end
        one_bit(1'b1, r);
        ack = ~r;
    endtask

    task automatic recv_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            one_bit(1'b1, d[i]);
        end
        one_bit(last, r);
    endtask

    // ==========================================================
    // Register access
    task automatic write_reg(input logic [7:0] ptr, input logic [7:0] d, output logic ok);
        logic a0, a1, a2;
        start();
        send_byte({TARGET_ADDR, 1'b0}, a0);
        send_byte(ptr, a1);
        send_byte(d, a2);
        stop();
        ok = a0 & a1 & a2;
    endtask

    task automatic read_reg(input logic [7:0] ptr, output logic [7:0] d, output logic ok);
        logic a0, a1, a2;
        start();
        send_byte({TARGET_ADDR, 1'b0}, a0);
        send_byte(ptr, a1);
        start();
        send_byte({TARGET_ADDR, 1'b1}, a2);
        recv_byte(1'b1, d);
        stop();
        ok = a0 & a1 & a2;
    endtask
endmodule

`default_nettype wire

// ===== tb/pmic_fault_event_flags_test.sv
// Self-checking bench for the fault and event flag block.
// Assumes the host model above and one 25 MHz clock with synchronous reset.
`default_nettype none

module pmic_fault_event_flags_test
    import pmic_flags_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic scl, host_sda, sda_out, sda_oe_n, irq;
    wire logic sda_line;
    analog_type ana;
    int miscompares = 0;
    int checks_done = 0;

    // Open-drain wire with pull-up
    assign sda_line = host_sda & (sda_oe_n | sda_out);

    always #20 clk = ~clk;

    pmic_fault_event_flags u_pmic_fault_event_flags (
        .CLK_I(clk),
        .RST_I(rst),
        .SCL_I(scl),
        .SDA_I(sda_line),
        .SDA_O(sda_out),
        .SDA_OE_N_O(sda_oe_n),
        .ANALOG_I(ana),
        .INT_REQ_O(irq)
    );

    i2c_host_model u_i2c_host_model (
        .clk_i(clk),
        .scl_o(scl),
        .sda_o(host_sda),
        .sda_i(sda_line)
    );

    // ==========================================================
    // Checking helpers
    task automatic test_done();
        if (miscompares == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
        logic ok;
        u_i2c_host_model.write_reg(ptr, d, ok);
        check({7'h00, ok}, 8'h01, "write acknowledge");
    endtask

    task automatic rd(input logic [7:0] ptr, input logic [7:0] exp);
        logic ok;
        logic [7:0] d;
        u_i2c_host_model.read_reg(ptr, d, ok);
        check({7'h00, ok}, 8'h01, "read acknowledge");
        check(d, exp, "register read");
    endtask

    // Detector changes land just after an edge and get time to pass the synchronisers
    task automatic event_drive(input int idx, input logic fire);
        @(posedge clk);
        #1;
        case (idx)
            0: ana.rail_good[0] = ~fire;
            1: ana.overcurrent[2] = fire;
            2: ana.undervoltage = fire;
            3: ana.power_fault_off = fire;
            4: ana.die_critical = fire;
            default: ana.external_enable_pin = ~fire;
        endcase
        repeat (8) @(posedge clk);
    endtask

    // ==========================================================
    // Main sequence
    logic [7:0] cause_exp [6] = '{8'h00, 8'h00, 8'h04, 8'h02, 8'h01, 8'h08};
    logic [7:0] flags_exp [6] = '{8'h80, 8'h80, 8'h08, 8'h08, 8'h88, 8'h08};
    logic ack;
    logic [7:0] burst_lo, burst_hi;

    initial begin
        ana = '0;
        ana.rail_good = 8'hFF;
        ana.external_enable_pin = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        rst = 1'b0;
        repeat (10) @(posedge clk);
        rd(REG_FLAGS, 8'h00);
        rd(REG_MASKS, 8'hFF);
        rd(REG_STATUS, 8'h00);
        rd(REG_CAUSE, 8'h00);
        @(posedge clk);
        #1;
        ana.die_hot = 1'b1;
        repeat (8) @(posedge clk);
        rd(REG_FLAGS, 8'h81);
        rd(REG_STATUS, 8'h01);
        check({7'h00, irq}, 8'h00, "masked request");
        wr(REG_MASKS, 8'h00);
        rd(REG_MASKS, 8'h76);
        check({7'h00, irq}, 8'h01, "unmasked request");
        wr(REG_FLAGS, 8'h00);
        rd(REG_FLAGS, 8'h81);
        wr(REG_FLAGS, 8'h01);
        rd(REG_FLAGS, 8'h80);
        @(posedge clk);
        #1;
        ana.die_hot = 1'b0;
        repeat (8) @(posedge clk);
        rd(REG_STATUS, 8'h00);
        rd(REG_FLAGS, 8'h80);
        wr(REG_FLAGS, 8'h80);
        rd(REG_FLAGS, 8'h00);
        check({7'h00, irq}, 8'h00, "request after clear");
        wr(REG_STATUS, 8'hFF);
        rd(REG_STATUS, 8'h00);
        rd(8'h10, UNMAPPED_DATA);
        // Foreign address must be left unanswered
        u_i2c_host_model.start();
        u_i2c_host_model.send_byte({TARGET_ADDR_DEFAULT ^ 7'h01, 1'b0}, ack);
        u_i2c_host_model.stop();
        check({7'h00, ack}, 8'h00, "foreign address");
        for (int i = 0; i < 6; i++) begin
            event_drive(i, 1'b1);
            rd(REG_CAUSE, cause_exp[i]);
            rd(REG_FLAGS, flags_exp[i]);
            check({7'h00, irq}, 8'h01, "event request");
            event_drive(i, 1'b0);
            wr(REG_CAUSE, 8'h00);
            rd(REG_CAUSE, cause_exp[i]);
            wr(REG_CAUSE, cause_exp[i]);
            wr(REG_FLAGS, flags_exp[i]);
            rd(REG_CAUSE, 8'h00);
            rd(REG_FLAGS, 8'h00);
        end
        // Detector edge timed to meet the write pulse three clocks after the last data bit
        fork
            wr(REG_CAUSE, 8'h04);
            begin
                repeat (546) @(posedge clk);
                #1;
                ana.undervoltage = 1'b1;
            end
        join
        rd(REG_CAUSE, 8'h04);
        event_drive(2, 1'b0);
        wr(REG_CAUSE, 8'h04);
        wr(REG_FLAGS, 8'h08);
        rd(REG_CAUSE, 8'h00);
        rd(REG_FLAGS, 8'h00);
        // Two-byte read walks the pointer from masks to status
        u_i2c_host_model.start();
        u_i2c_host_model.send_byte({TARGET_ADDR_DEFAULT, 1'b0}, ack);
        u_i2c_host_model.send_byte(REG_MASKS, ack);
        u_i2c_host_model.start();
        u_i2c_host_model.send_byte({TARGET_ADDR_DEFAULT, 1'b1}, ack);
        u_i2c_host_model.recv_byte(1'b0, burst_lo);
        u_i2c_host_model.recv_byte(1'b1, burst_hi);
        u_i2c_host_model.stop();
        check({7'h00, ack}, 8'h01, "burst acknowledge");
        check(burst_lo, 8'h76, "first burst byte");
        check(burst_hi, 8'h00, "second burst byte");
        test_done();
    end

    // Cuts a hung run short
    initial begin
        repeat (90000) @(posedge clk);
        miscompares++;
        $display("wrong value at %0t: run did not finish", $time);
        test_done();
    end
endmodule

`default_nettype wire
